// ---- logic/frs_pkg.sv ----
// Package for the frequency ramp sequencer: register map, field layouts, constants.
// Assumes one AHB-Lite slave on hclk with word-aligned 32-bit registers.
package frs_pkg;
    localparam int FRS_SEGS = 8;
    localparam int FRS_NUM_W = 24;
    localparam int FRS_LEN_W = 16;
    // Register byte offsets
    localparam logic [7:0] FRS_OFF_CTRL = 8'h00;
    localparam logic [7:0] FRS_OFF_STATUS = 8'h04;
    localparam logic [7:0] FRS_OFF_IRQ_STAT = 8'h08;
    localparam logic [7:0] FRS_OFF_IRQ_MASK = 8'h0C;
    localparam logic [7:0] FRS_OFF_NUM = 8'h10;
    localparam logic [7:0] FRS_OFF_SEG_BASE = 8'h40;
    localparam logic [7:0] FRS_OFF_SEG_CFG_BASE = 8'h60;
    // Control fields
    localparam int FRS_CTRL_EN_BIT = 0;
    localparam int FRS_CTRL_PM_BIT = 1;
    localparam int FRS_CTRL_FIRST_LSB = 4;
    // Segment config fields
    localparam int FRS_CFG_NEXT_LSB = 0;
    localparam int FRS_CFG_HALF_BIT = 4;
    localparam int FRS_CFG_TRIG_BIT = 5;
    localparam int FRS_CFG_FLAG_LSB = 8;
    // Segment word: increment in [31:16], step count minus one in [15:0]
    localparam int FRS_SEG_INC_LSB = 16;
    localparam logic [31:0] FRS_CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] FRS_SEG_RST = 32'h0000_0000;
    localparam int FRS_IRQ_W = 3;
    localparam int FRS_IRQ_SEG_BIT = 0;
    localparam int FRS_IRQ_WRAP_BIT = 1;
    localparam int FRS_IRQ_TRIG_BIT = 2;

    typedef struct packed {
        logic [1:0] flags;
        logic trig_wait;
        logic half_rate;
        logic [2:0] next_seg;
    } frs_seg_cfg_t;

    typedef enum logic [2:0] {
        FRS_IDLE = 3'b001,
        FRS_WAIT = 3'b010,
        FRS_RUN = 3'b100
    } frs_state_t;
endpackage

// ---- logic/frs_ramp_seq.sv ----
// Frequency ramp sequencer with AHB-Lite register slave and level interrupt.
// Assumes the ramp clock is hclk; the trigger pin is asynchronous to it.
// How it works
// [R01] Step count field holds up to 65536 steps (stored as count minus one).
// [R02] Half-rate segments apply one increment every two clock cycles.
// [R03] Eight segments, each with its own next index, chainable in any order.
// [R04] Per-segment flag selection drives flag pins when that segment begins.
// [R05] A segment may wait for a rising trigger edge before it starts.
// [R06] Software keeps end frequency equal to start; no numerator reset on wrap.
// [R07] Software lowers rate or sets half rate if a segment is too long.
// [R08] Each step adds the signed increment, then advances on count or trigger.
`timescale 1ns/1ps
module frs_ramp_seq
    import frs_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Ramp pins
    input wire logic ramp_trigger,
    output logic aux_pin_one,
    output logic aux_pin_two,
    output logic [FRS_NUM_W-1:0] frac_num,
    output logic ramp_phase_mod_enable,
    output logic irq
);
    logic [31:0] ctrl_reg;
    logic [31:0] seg_reg [FRS_SEGS];
    frs_seg_cfg_t cfg_reg [FRS_SEGS];
    logic [FRS_IRQ_W-1:0] irq_stat_reg;
    logic [FRS_IRQ_W-1:0] irq_mask_reg;
    frs_state_t state_reg;
    logic [2:0] seg_reg_idx;
    logic [FRS_LEN_W-1:0] step_reg;
    logic phase_reg;
    logic [2:0] trig_sync_reg;
    logic trig_lvl_reg;
    logic trig_rise;
    logic step_en;
    logic last_step;
    logic seg_start;
    logic [2:0] start_idx;

    // Address phase capture
    logic ap_valid_reg;
    logic ap_write_reg;
    logic [7:0] ap_addr_reg;
    logic ap_take;
    assign ap_take = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_valid_reg <= 1'b0;
            ap_write_reg <= 1'b0;
            ap_addr_reg <= 8'h00;
        end else if (hready) begin
            ap_valid_reg <= ap_take;
            ap_write_reg <= hwrite;
            ap_addr_reg <= haddr[7:0];
        end
    end

    logic wr_en;
    logic rd_en;
    assign wr_en = ap_valid_reg && ap_write_reg;
    assign rd_en = ap_take && !hwrite;

    function automatic logic is_seg(input logic [7:0] a, input logic [7:0] base);
        return (a[7:5] == base[7:5]) && (a[1:0] == 2'b00);
    endfunction

    // Field positions live in the package; the struct packing is internal only
    function automatic frs_seg_cfg_t cfg_unpack(input logic [31:0] w);
        frs_seg_cfg_t c;
        c.next_seg = w[FRS_CFG_NEXT_LSB +: 3];
        c.half_rate = w[FRS_CFG_HALF_BIT];
        c.trig_wait = w[FRS_CFG_TRIG_BIT];
        c.flags = w[FRS_CFG_FLAG_LSB +: 2];
        return c;
    endfunction

    function automatic logic [31:0] cfg_pack(input frs_seg_cfg_t c);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[FRS_CFG_NEXT_LSB +: 3] = c.next_seg;
        w[FRS_CFG_HALF_BIT] = c.half_rate;
        w[FRS_CFG_TRIG_BIT] = c.trig_wait;
        w[FRS_CFG_FLAG_LSB +: 2] = c.flags;
        return w;
    endfunction

    // Config registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg <= FRS_CTRL_RST;
            irq_mask_reg <= '0;
            for (int i = 0; i < FRS_SEGS; i++) begin
                seg_reg[i] <= FRS_SEG_RST;
                cfg_reg[i] <= '0;
            end
        end else if (wr_en) begin
            if (ap_addr_reg == FRS_OFF_CTRL) begin
                ctrl_reg <= hwdata;
            end
            if (ap_addr_reg == FRS_OFF_IRQ_MASK) begin
                irq_mask_reg <= hwdata[FRS_IRQ_W-1:0];
            end
            if (is_seg(ap_addr_reg, FRS_OFF_SEG_BASE)) begin
                seg_reg[ap_addr_reg[4:2]] <= hwdata; // [R01] [R03]
            end
            if (is_seg(ap_addr_reg, FRS_OFF_SEG_CFG_BASE)) begin
                cfg_reg[ap_addr_reg[4:2]] <= cfg_unpack(hwdata); // [R03]
            end
        end
    end

    // Read data registered in the data phase, from the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_en) begin
            hrdata <= 32'h0000_0000;
            if (haddr[7:0] == FRS_OFF_CTRL) hrdata <= ctrl_reg;
            if (haddr[7:0] == FRS_OFF_STATUS) begin
                hrdata <= {24'h0000_00, 1'b0, seg_reg_idx, 1'b0, state_reg};
            end
            if (haddr[7:0] == FRS_OFF_IRQ_STAT) hrdata <= {29'h0000_0000, irq_stat_reg};
            if (haddr[7:0] == FRS_OFF_IRQ_MASK) hrdata <= {29'h0000_0000, irq_mask_reg};
            if (haddr[7:0] == FRS_OFF_NUM) hrdata <= {8'h00, frac_num};
            if (is_seg(haddr[7:0], FRS_OFF_SEG_BASE)) hrdata <= seg_reg[haddr[4:2]];
            if (is_seg(haddr[7:0], FRS_OFF_SEG_CFG_BASE)) begin
                hrdata <= cfg_pack(cfg_reg[haddr[4:2]]);
            end
        end
    end

    // Trigger pin: three flops, edge once second and third agree
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            trig_sync_reg <= 3'b000;
            trig_lvl_reg <= 1'b0;
        end else begin
            trig_sync_reg <= {trig_sync_reg[1:0], ramp_trigger};
            if (trig_sync_reg[1] == trig_sync_reg[2]) trig_lvl_reg <= trig_sync_reg[2];
        end
    end
    assign trig_rise = (trig_sync_reg[1] == trig_sync_reg[2]) && trig_sync_reg[2]
        && !trig_lvl_reg;

    // Sequencer
    assign start_idx = ctrl_reg[FRS_CTRL_FIRST_LSB +: 3];
    assign step_en = (state_reg == FRS_RUN)
        && (!cfg_reg[seg_reg_idx].half_rate || phase_reg); // [R02]
    assign last_step = step_en && (step_reg == seg_reg[seg_reg_idx][FRS_LEN_W-1:0]); // [R01]
    logic [2:0] nxt_idx;
    assign nxt_idx = cfg_reg[seg_reg_idx].next_seg;
    assign seg_start = (state_reg == FRS_IDLE && ctrl_reg[FRS_CTRL_EN_BIT]
            && !cfg_reg[start_idx].trig_wait)
        || (state_reg == FRS_WAIT && trig_rise)
        || (last_step && !cfg_reg[nxt_idx].trig_wait);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= FRS_IDLE;
            seg_reg_idx <= 3'd0;
            step_reg <= '0;
            phase_reg <= 1'b0;
        end else if (!ctrl_reg[FRS_CTRL_EN_BIT]) begin
            state_reg <= FRS_IDLE;
            seg_reg_idx <= start_idx;
        end else begin
            unique case (state_reg)
                FRS_IDLE: begin
                    seg_reg_idx <= start_idx;
                    step_reg <= '0;
                    phase_reg <= 1'b0;
                    state_reg <= cfg_reg[start_idx].trig_wait ? FRS_WAIT : FRS_RUN; // [R05]
                end
                FRS_WAIT: begin
                    if (trig_rise) state_reg <= FRS_RUN; // [R05]
                end
                FRS_RUN: begin
                    phase_reg <= ~phase_reg;
                    if (last_step) begin
                        seg_reg_idx <= nxt_idx; // [R08] [R03]
                        step_reg <= '0;
                        phase_reg <= 1'b0;
                        if (cfg_reg[nxt_idx].trig_wait) state_reg <= FRS_WAIT; // [R08]
                    end else if (step_en) begin
                        step_reg <= step_reg + 1'b1;
                    end
                end
            endcase
        end
    end

    // Numerator accumulator; no reset on wrap, software keeps it closed
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            frac_num <= '0;
        end else if (wr_en && ap_addr_reg == FRS_OFF_NUM) begin
            frac_num <= hwdata[FRS_NUM_W-1:0];
        end else if (step_en) begin
            frac_num <= frac_num + FRS_NUM_W'($signed(seg_reg[seg_reg_idx][31:16])); // [R08]
        end
    end

    // Flags at segment start; index known one cycle later so use target
    logic [2:0] start_tgt;
    assign start_tgt = (state_reg == FRS_RUN) ? nxt_idx
        : (state_reg == FRS_WAIT) ? seg_reg_idx : start_idx;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            aux_pin_one <= 1'b0;
            aux_pin_two <= 1'b0;
            ramp_phase_mod_enable <= 1'b0;
        end else begin
            ramp_phase_mod_enable <= ctrl_reg[FRS_CTRL_PM_BIT];
            if (seg_start) begin
                aux_pin_one <= cfg_reg[start_tgt].flags[0]; // [R04]
                aux_pin_two <= cfg_reg[start_tgt].flags[1]; // [R04]
            end
        end
    end

    // Interrupts: set wins over read-clear
    logic [FRS_IRQ_W-1:0] ev;
    logic rd_stat;
    assign ev = {trig_rise && state_reg == FRS_WAIT, last_step && nxt_idx == start_idx,
        seg_start};
    assign rd_stat = rd_en && haddr[7:0] == FRS_OFF_IRQ_STAT;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) irq_stat_reg <= '0;
        else irq_stat_reg <= (rd_stat ? '0 : irq_stat_reg) | ev;
    end
    assign irq = |(irq_stat_reg & irq_mask_reg);

    a_num_step: assert property (@(posedge hclk) disable iff (!hresetn)
        step_en && !(wr_en && ap_addr_reg == FRS_OFF_NUM) |=>
        frac_num == $past(frac_num) + FRS_NUM_W'($signed($past(seg_reg[seg_reg_idx][31:16]))))
        else $error("numerator step wrong"); // [R08]
    a_half_rate: assert property (@(posedge hclk) disable iff (!hresetn)
        step_en && cfg_reg[seg_reg_idx].half_rate && !last_step |=> !step_en)
        else $error("half rate stepped twice"); // [R02]
    a_wait_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        state_reg == FRS_WAIT && !trig_rise && ctrl_reg[0] |=> state_reg == FRS_WAIT)
        else $error("left wait without trigger"); // [R05]
    a_seg_chain: assert property (@(posedge hclk) disable iff (!hresetn)
        last_step && ctrl_reg[0] |=> seg_reg_idx == $past(nxt_idx) && step_reg == 0)
        else $error("bad segment chain"); // [R03]
    a_len_end: assert property (@(posedge hclk) disable iff (!hresetn)
        state_reg == FRS_RUN |-> step_reg <= seg_reg[seg_reg_idx][15:0])
        else $error("step count overrun"); // [R01]
    a_flag_out: assert property (@(posedge hclk) disable iff (!hresetn)
        seg_start |=> aux_pin_one == $past(cfg_reg[start_tgt].flags[0]))
        else $error("flag mismatch"); // [R04]
    a_irq_level: assert property (@(posedge hclk) disable iff (!hresetn)
        irq == |(irq_stat_reg & irq_mask_reg)) else $error("irq wrong");
    a_ev_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
        ev[0] |=> irq_stat_reg[0]) else $error("event lost"); // [R04]
    a_stat_clear: assert property (@(posedge hclk) disable iff (!hresetn)
        rd_stat && ev == '0 |=> irq_stat_reg == '0)
        else $error("status not cleared by read");
    c_wrap: cover property (@(posedge hclk) ev[FRS_IRQ_WRAP_BIT]);
    c_trig: cover property (@(posedge hclk) state_reg == FRS_WAIT ##1 state_reg == FRS_RUN);
    c_half: cover property (@(posedge hclk) last_step && cfg_reg[seg_reg_idx].half_rate);
endmodule

// ---- tb/frs_trig_src.sv ----
// Far-side trigger source for the ramp sequencer.
// Assumes fire is a one-cycle request from the bench; the edge lands off the clock phase.
`timescale 1ns/1ps
module frs_trig_src (
    // Clock and request
    input wire logic hclk,
    input wire logic fire,
    // Trigger pin
    output logic ramp_trigger
);
    initial ramp_trigger = 1'b0;
    // Held several cycles so the three-flop synchroniser sees a clean edge
    always @(posedge fire) begin
        #7 ramp_trigger = 1'b1;
        repeat (6) @(posedge hclk);
        #11 ramp_trigger = 1'b0;
    end
endmodule

// ---- tb/tb.sv ----
// Self-checking bench: registers, step rates, flags, chaining, trigger and interrupt.
// Assumes one AHB-Lite slave whose hreadyout is fed back as hready.
`timescale 1ns/1ps
module tb;
    import frs_pkg::*;
    typedef struct packed {logic [15:0] inc; logic half; logic [1:0] flags;} frs_row_t;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, fire = 1'b0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rd_data;
    logic [1:0] htrans = 2'b00;
    logic [2:0] hsize = 3'b010;
    logic hready, hresp, ramp_trigger, aux_pin_one, aux_pin_two, pm_en, irq;
    logic [FRS_NUM_W-1:0] frac_num, f0;
    int n_errors = 0, n_compared = 0, e;
    frs_row_t rows [5] = '{'{16'h0002, 1'b0, 2'b01}, '{16'hFFFD, 1'b1, 2'b10},
        '{16'h0001, 1'b1, 2'b11}, '{16'h8000, 1'b0, 2'b00}, '{16'h7FFF, 1'b1, 2'b01}};

    always #20 hclk = ~hclk;

    frs_ramp_seq dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .ramp_trigger(ramp_trigger),
        .aux_pin_one(aux_pin_one), .aux_pin_two(aux_pin_two), .frac_num(frac_num),
        .ramp_phase_mod_enable(pm_en), .irq(irq));
    frs_trig_src u_trig (.hclk(hclk), .fire(fire), .ramp_trigger(ramp_trigger));

    task complete_run;
        $display("Compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
            n_errors++;
        end
    endtask

    task ready_edge;
        int i;
        i = 0;
        do begin
            @(posedge hclk);
            i++;
        end while (hready !== 1'b1 && i < 50);
        if (hready !== 1'b1) begin
            n_errors++;
            complete_run;
        end
    endtask

    // Called just after a clock edge; returns at the edge that ends the data phase
    task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0000_00, a};
        htrans <= 2'b10;
        hwrite <= wr;
        ready_edge;
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= d;
        ready_edge;
        rd_data = hrdata;
    endtask

    initial begin
        #2_000_000;
        n_errors++;
        complete_run;
    end

    initial begin
        repeat (3) @(posedge hclk);
        chk("frac_num in reset", 32'h0000_0000, 32'(frac_num));
        chk("hreadyout in reset", 32'h0000_0001, 32'(hready));
        chk("hresp okay", 32'h0000_0000, 32'(hresp));
        hresetn <= 1'b1;
        ahb(1'b0, FRS_OFF_CTRL, 32'h0000_0000);
        chk("ctrl reset", FRS_CTRL_RST, rd_data);
        ahb(1'b0, FRS_OFF_STATUS, 32'h0000_0000);
        chk("status reset", 32'h0000_0001, rd_data);
        ahb(1'b0, FRS_OFF_SEG_BASE, 32'h0000_0000);
        chk("seg0 reset", FRS_SEG_RST, rd_data);
        ahb(1'b1, 8'h20, 32'hFFFF_FFFF);
        ahb(1'b0, 8'h20, 32'h0000_0000);
        chk("unmapped", 32'h0000_0000, rd_data);
        ahb(1'b1, FRS_OFF_IRQ_MASK, 32'h0000_0002);
        ahb(1'b0, FRS_OFF_IRQ_MASK, 32'h0000_0000);
        chk("irq mask", 32'h0000_0002, rd_data);
        for (int i = 0; i < 5; i++) begin
            ahb(1'b1, FRS_OFF_CTRL, 32'h0000_0000);
            ahb(1'b1, FRS_OFF_SEG_BASE, {rows[i].inc, 16'hFFFF});
            ahb(1'b1, FRS_OFF_SEG_CFG_BASE,
                {22'h0, rows[i].flags, 3'h0, rows[i].half, 4'h0});
            ahb(1'b1, FRS_OFF_CTRL, {30'h0, i[0], 1'b1});
            repeat (4) @(posedge hclk);
            f0 = frac_num;
            repeat (20) @(posedge hclk);
            e = (rows[i].half ? 10 : 20) * $signed(rows[i].inc);
            chk("step delta", 32'(e[23:0]), 32'(FRS_NUM_W'(frac_num - f0)));
            chk("flags", 32'(rows[i].flags), 32'({aux_pin_two, aux_pin_one}));
            chk("phase mod", 32'(i[0]), 32'(pm_en));
        end
        ahb(1'b1, FRS_OFF_CTRL, 32'h0000_0000);
        ahb(1'b1, FRS_OFF_NUM, 32'h0000_1000);
        ahb(1'b0, FRS_OFF_NUM, 32'h0000_0000);
        chk("numerator", 32'h0000_1000, rd_data);
        // One step each, stride-3 chain; last increment closes the lap on the start value
        for (int n = 0; n < FRS_SEGS; n++) begin
            ahb(1'b1, FRS_OFF_SEG_BASE + 8'(4 * n),
                {(n == 7) ? 16'hFF81 : 16'(1 << n), 16'h0000});
            ahb(1'b1, FRS_OFF_SEG_CFG_BASE + 8'(4 * n),
                {26'h0, n == 0, 2'b00, 3'((n + 3) % 8)});
        end
        ahb(1'b0, FRS_OFF_IRQ_STAT, 32'h0000_0000);
        ahb(1'b1, FRS_OFF_CTRL, 32'h0000_0001);
        repeat (10) @(posedge hclk);
        ahb(1'b0, FRS_OFF_STATUS, 32'h0000_0000);
        chk("status waiting", 32'h0000_0002, rd_data);
        chk("frac before trigger", 32'h0000_1000, 32'(frac_num));
        fire <= 1'b1;
        @(posedge hclk);
        fire <= 1'b0;
        for (int k = 0; k < 200 && frac_num === 24'h00_1000; k++) @(posedge hclk);
        chk("lap started", 32'h0000_1001, 32'(frac_num));
        repeat (20) @(posedge hclk);
        chk("frac after lap", 32'h0000_1000, 32'(frac_num));
        ahb(1'b0, FRS_OFF_STATUS, 32'h0000_0000);
        chk("status rewait", 32'h0000_0002, rd_data);
        chk("irq wrap", 32'h0000_0001, 32'(irq));
        ahb(1'b0, FRS_OFF_IRQ_STAT, 32'h0000_0000);
        chk("irq status", 32'h0000_0007, rd_data);
        @(posedge hclk);
        chk("irq cleared", 32'h0000_0000, 32'(irq));
        ahb(1'b0, FRS_OFF_IRQ_STAT, 32'h0000_0000);
        chk("irq status clear", 32'h0000_0000, rd_data);
        // Start from segment 3: runs to segment 5, then waits at segment 0
        ahb(1'b1, FRS_OFF_CTRL, 32'h0000_0000);
        ahb(1'b1, FRS_OFF_CTRL, 32'h0000_0031);
        repeat (20) @(posedge hclk);
        ahb(1'b0, FRS_OFF_STATUS, 32'h0000_0000);
        chk("first segment wait", 32'h0000_0002, rd_data);
        chk("partial lap", 32'h0000_0FFF, 32'(frac_num));
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        chk("frac second reset", 32'h0000_0000, 32'(frac_num));
        complete_run;
    end
endmodule
